// ---- hw/err_status_pkg.sv ----
// constants and carrier types for the pci-side error status register
// Summary of operation
// - Bit 15 sets on an address/attribute parity error as potential target, a data error as write target, or as read master.
// - Bit 15 sets whatever the parity response enable holds.
// - Bit 14 sets whenever system error is seen asserted on the secondary bus.
// - Bit 13 sets when a transaction the bridge masters ends in master abort.
// - Bit 12 sets when the bridge receives a target abort from an addressed target.
// - Bit 11 sets when the bridge, as target, ends a transaction with target abort.
// - Bits 10 to 9 always read 01b, medium decode timing.
// - Bit 8 sets only as master with parity response enabled, on parity error asserted on a read or seen on a write.
// - Bit 7 always reads 1, fast back-to-back capable.
// - Bit 5 always reads 1, 66 MHz capable.
// - Bit 6 and bits 4 to 0 read zero and ignore writes.
package err_status_pkg;
  // ==========================================
  // register map
  localparam logic [7:0]  STATUS_OFFSET    = 8'h1e;
  // bit 5 is a tie-off that reads 1 on top of this reset image
  localparam logic [15:0] STATUS_RESET     = 16'h0280;
  localparam int          PARITY_BIT       = 15;
  localparam int          SYSTEM_BIT       = 14;
  localparam int          MASTER_TERM_BIT  = 13;
  localparam int          TREC_BIT         = 12;
  localparam int          TSIG_BIT         = 11;
  localparam int          SEL_TIMING_LSB   = 9;
  localparam int          DPAR_BIT         = 8;
  localparam int          BACK_TO_BACK_BIT = 7;
  localparam int          HIGH_CLOCK_BIT   = 5;
  localparam logic [1:0]  SEL_TIMING       = 2'h1;
  localparam logic [15:0] FLAG_MASK        = 16'hf900;
  localparam logic [15:0] RESERVED_MASK    = 16'h005f;
  // ==========================================
  // event carrier, one-cycle pulses from the secondary bus engine
  typedef struct packed {
    logic addr_parity_target;
    logic data_parity_write_target;
    logic data_parity_read_master;
    logic system_fault_seen;
    logic master_abort;
    logic target_abort_received;
    logic target_abort_signalled;
    logic master_read_parity_asserted;
    logic master_write_parity_seen;
  } bus_event_type;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  addr;
    logic [1:0]  byte_en;
    logic [15:0] wdata;
  } cfg_req_type;
endpackage : err_status_pkg

// ---- hw/event_flag.sv ----
// one sticky write-one-to-clear flag
`timescale 1ns/1ns
module event_flag (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clear_i,
  output logic      flag_o
);
  typedef struct packed { logic flag; } flag_state_type;
  flag_state_type state, next_state;

  // ==========================================
  // set beats clear
  always_comb begin
    next_state = state;
    if (clear_i)
      next_state.flag = 1'b0;
    if (set_i)
      next_state.flag = 1'b1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      state <= '0;
    else
      state <= next_state;
  end

  assign flag_o = state.flag;

  flag_sticky_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    state.flag && !clear_i |=> state.flag
  ) else $error("flag dropped without clear");
  set_wins_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    set_i |=> state.flag
  ) else $error("event lost");
  clear_works_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    clear_i && !set_i |=> !state.flag
  ) else $error("clear ignored");
endmodule : event_flag

// ---- hw/pci_side_error_status.sv ----
// pci-side error status register with sticky event flags
`timescale 1ns/1ns
module pci_side_error_status (
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_i,
  input  wire err_status_pkg::bus_event_type event_i,
  input  wire logic                          parity_response_enable_i,
  input  wire err_status_pkg::cfg_req_type   req_i,
  output logic [15:0]                        rdata_o,
  output logic                               rvalid_o
);
  import err_status_pkg::*;

  typedef struct packed {
    logic [15:0] rdata;
    logic        rvalid;
  } bus_state_type;

  bus_state_type state, next_state;
  logic [15:0]   set_vec;
  logic [15:0]   clr_vec;
  logic [15:0]   flags;
  logic [15:0]   status_view;
  logic          hit_write;

  // ==========================================
  // address decode, shared by the read and write paths
  function automatic logic status_hit(input logic [7:0] addr);
    return addr == STATUS_OFFSET;
  endfunction : status_hit

  // ==========================================
  // event decode
  always_comb begin
    set_vec = '0;
    set_vec[PARITY_BIT] = event_i.addr_parity_target | event_i.data_parity_write_target
                          | event_i.data_parity_read_master;
    set_vec[SYSTEM_BIT] = event_i.system_fault_seen;
    set_vec[MASTER_TERM_BIT] = event_i.master_abort;
    set_vec[TREC_BIT]   = event_i.target_abort_received;
    set_vec[TSIG_BIT]   = event_i.target_abort_signalled;
    set_vec[DPAR_BIT]   = parity_response_enable_i
                          & (event_i.master_read_parity_asserted | event_i.master_write_parity_seen);
  end

  // ==========================================
  // write-one-to-clear decode, upper byte lane only carries flags
  assign hit_write = req_i.write && status_hit(req_i.addr) && req_i.byte_en[1];
  assign clr_vec   = hit_write ? (req_i.wdata & FLAG_MASK) : 16'h0000;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_flag
      if (FLAG_MASK[g]) begin : g_live
        event_flag u_flag (
          .ref_clk_i (ref_clk_i),
          .rst_i     (rst_i),
          .set_i     (set_vec[g]),
          .clear_i   (clr_vec[g]),
          .flag_o    (flags[g])
        );
      end else begin : g_none
        assign flags[g] = 1'b0;
      end
    end
  endgenerate

  // ==========================================
  // read view
  always_comb begin
    status_view = flags & FLAG_MASK;
    status_view[SEL_TIMING_LSB +: 2] = SEL_TIMING;
    status_view[BACK_TO_BACK_BIT] = 1'b1;
    status_view[HIGH_CLOCK_BIT] = 1'b1;
    status_view = status_view & ~RESERVED_MASK;
  end

  always_comb begin
    next_state        = state;
    next_state.rvalid = req_i.read && status_hit(req_i.addr);
    // unmapped reads return zero with rvalid low
    next_state.rdata  = next_state.rvalid ? status_view : 16'h0000;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      state <= '0;
    else
      state <= next_state;
  end

  assign rdata_o  = state.rdata;
  assign rvalid_o = state.rvalid;

  // ==========================================
  // assertions
  // constant fields read back
  const_fields_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rvalid_o |-> rdata_o[SEL_TIMING_LSB +: 2] == SEL_TIMING
      && rdata_o[BACK_TO_BACK_BIT] && rdata_o[HIGH_CLOCK_BIT]
  ) else $error("fixed field wrong");

  reserved_zero_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rvalid_o |-> (rdata_o & RESERVED_MASK) == 16'h0000
  ) else $error("reserved bit set");

  back_to_back_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rvalid_o |-> rdata_o[BACK_TO_BACK_BIT]
  ) else $error("back-to-back bit clear");

  high_clock_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rvalid_o |-> rdata_o[HIGH_CLOCK_BIT]
  ) else $error("high clock bit clear");

  parity_set_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    event_i.addr_parity_target |=> flags[PARITY_BIT]
  ) else $error("parity flag missed");

  parity_free_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !parity_response_enable_i && event_i.data_parity_read_master |=> flags[PARITY_BIT]
  ) else $error("parity flag gated");

  parity_write_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    event_i.data_parity_write_target |=> flags[PARITY_BIT]
  ) else $error("write parity missed");

  parity_read_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    event_i.data_parity_read_master |=> flags[PARITY_BIT]
  ) else $error("read parity missed");

  dpar_gate_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !flags[DPAR_BIT] && !parity_response_enable_i |=> !flags[DPAR_BIT]
  ) else $error("data parity ungated");

  dpar_read_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    parity_response_enable_i && event_i.master_read_parity_asserted |=> flags[DPAR_BIT]
  ) else $error("read data parity missed");

  dpar_write_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    parity_response_enable_i && event_i.master_write_parity_seen |=> flags[DPAR_BIT]
  ) else $error("write data parity missed");

  system_set_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    event_i.system_fault_seen |=> flags[SYSTEM_BIT]
  ) else $error("system fault missed");

  master_term_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    event_i.master_abort |=> flags[MASTER_TERM_BIT]
  ) else $error("master abort missed");

  trec_set_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    event_i.target_abort_received |=> flags[TREC_BIT]
  ) else $error("target abort missed");

  tsig_set_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    event_i.target_abort_signalled |=> flags[TSIG_BIT]
  ) else $error("signalled abort missed");

  read_flags_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    req_i.read && status_hit(req_i.addr) |=>
      rvalid_o && rdata_o[15:8] == {$past(flags[15:11]), 2'h1, $past(flags[8])}
  ) else $error("read data stale");

  parity_clear_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    hit_write && req_i.wdata[PARITY_BIT] && !set_vec[PARITY_BIT] |=> !flags[PARITY_BIT]
  ) else $error("parity clear ignored");

  system_clear_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    hit_write && req_i.wdata[SYSTEM_BIT] && !set_vec[SYSTEM_BIT] |=> !flags[SYSTEM_BIT]
  ) else $error("system clear ignored");

  tsig_clear_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    hit_write && req_i.wdata[TSIG_BIT] && !set_vec[TSIG_BIT] |=> !flags[TSIG_BIT]
  ) else $error("signalled abort clear ignored");

  dpar_clear_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    hit_write && req_i.wdata[DPAR_BIT] && !set_vec[DPAR_BIT] |=> !flags[DPAR_BIT]
  ) else $error("data parity clear ignored");

  low_lane_write_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    req_i.write && !req_i.byte_en[1] && flags[PARITY_BIT] |=> flags[PARITY_BIT]
  ) else $error("low lane write cleared a flag");
endmodule : pci_side_error_status

// ---- dv/pci_agent_model.sv ----
// behavioural model of the secondary bus agents that raise error events
`timescale 1ns/1ns
module pci_agent_model (
  output err_status_pkg::bus_event_type event_o
);
  import err_status_pkg::*;
  // ==========================================
  // agents raise events
  task automatic emit(input logic [8:0] pattern);
    event_o = pattern;
  endtask : emit
  initial event_o = '0;
endmodule : pci_agent_model

// ---- dv/pci_side_error_status_tb.sv ----
// self-checking bench for the pci-side error status register
`timescale 1ns/1ns
module pci_side_error_status_tb;
  import err_status_pkg::*;
  logic          ref_clk_i  = 1'b0;
  logic          rst_i      = 1'b1;
  logic          pre        = 1'b0;
  cfg_req_type   req        = '0;
  bus_event_type ev;
  logic [15:0]   rdata;
  logic          rvalid;
  int            fails      = 0;
  int            num_checks = 0;
  logic [31:0]   seed       = 32'h28de;
  logic [15:0]   flags      = '0;
  logic [16:0]   expected;
  logic [8:0]    prev_ev    = '0;
  logic          prev_pre   = 1'b0;
  logic          prev_rst   = 1'b1;
  cfg_req_type   prev_req   = '0;

  pci_agent_model agent (.event_o(ev));
  pci_side_error_status uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .event_i(ev),
    .parity_response_enable_i(pre), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid));

  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    repeat (32) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    return x;
  endfunction : lfsr_next

  // outputs seen at the falling edge answer the inputs of the last rising edge
  task automatic model_and_check();
    logic [15:0] set;
    set             = '0;
    set[PARITY_BIT] = |prev_ev[8:6];
    set[SYSTEM_BIT] = prev_ev[5];
    set[MASTER_TERM_BIT] = prev_ev[4];
    set[TREC_BIT]   = prev_ev[3];
    set[TSIG_BIT]   = prev_ev[2];
    set[DPAR_BIT]   = prev_pre & |prev_ev[1:0];
    expected = '0;
    if (!prev_rst && prev_req.read && prev_req.addr == STATUS_OFFSET)
      expected = {1'b1, STATUS_RESET | flags | (16'h0001 << HIGH_CLOCK_BIT)};
    if (prev_rst) flags = '0;
    else if (prev_req.write && prev_req.addr == STATUS_OFFSET && prev_req.byte_en[1])
      flags = (flags & ~(prev_req.wdata & FLAG_MASK)) | set;
    else flags = flags | set;
    num_checks++;
    if ({rvalid, rdata} !== expected) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, {rvalid, rdata}, expected);
    end
  endtask : model_and_check

  task automatic run_cycles(input int n, input logic hold_rst);
    logic [8:0] pattern;
    repeat (n) begin
      @(negedge ref_clk_i);
      model_and_check();
      seed = lfsr_next(seed);
      // sparse events, about one in eight per line
      pattern = seed[8:0] & seed[17:9] & seed[26:18];
      agent.emit(pattern);
      pre = seed[27];
      seed = lfsr_next(seed);
      req.read = seed[0];
      req.write = seed[1] & ~seed[0];
      req.addr = seed[2] ? STATUS_OFFSET : seed[15:8];
      req.byte_en = seed[5:4];
      req.wdata = seed[31:16];
      rst_i = hold_rst;
      // the agent's port settles later in this step, so keep our own copy
      prev_ev = pattern;
      prev_pre = pre;
      prev_req = req;
      prev_rst = hold_rst;
    end
  endtask : run_cycles

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================
  // tests
  initial begin
    run_cycles(16, 1'b1);
    $display("test reset done");
    run_cycles(3000, 1'b0);
    $display("test random traffic done");
    // second reset mid-run must drop every flag
    run_cycles(2, 1'b1);
    run_cycles(500, 1'b0);
    $display("test reset in mid-run done");
    report_and_stop();
  end

  // about 3500 cycles expected, limit set well beyond
  initial begin
    #20000;
    fails++;
    report_and_stop();
  end
endmodule : pci_side_error_status_tb
